//--- rtl/opaddr_pkg.sv
// Purpose: shared constants for the operand address decoder
// Assumes: 17-bit opcode, 16-bit byte addresses, eight address registers
// Notes: field positions and cycle figures only; no timing in ns needed
package opaddr_pkg;
  localparam int OPCODE_W = 17;
  localparam int ADDR_W = 16;
  localparam int AP_W = 5;
  localparam int NUM_AP = 4;
  localparam int REPEAT_W = 8;
  // opcode field positions
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int BASE_MSB = 4;
  localparam int BASE_LSB = 2;
  localparam int POST_MSB = 1;
  localparam int POST_LSB = 0;
  localparam int SHORT_FLAG_BIT = 7;
  localparam int SHORT_OFS_MSB = 6;
  localparam int FLAG_REL_BIT = 0;
  localparam int FLAG_OFS_MSB = 6;
  localparam int FLAG_OFS_LSB = 1;
  localparam int STEP_MSB = 11;
  localparam int STEP_LSB = 10;
  // mode_select_field codes (bit 7 clear)
  localparam logic [2:0] MODE_DIRECT = 3'h0;
  localparam logic [2:0] MODE_LONG = 3'h1;
  localparam logic [2:0] MODE_INDEX = 3'h2;
  localparam logic [2:0] MODE_INDIRECT = 3'h3;
  // post_modify_field codes
  localparam logic [1:0] POST_NONE = 2'h0;
  localparam logic [1:0] POST_INC = 2'h1;
  localparam logic [1:0] POST_DEC = 2'h2;
  localparam logic [1:0] POST_ADD_INDEX = 2'h3;
  // acc_pointer_step_field codes
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_PREDEC = 2'h1;
  localparam logic [1:0] STEP_PREINC = 2'h2;
  localparam logic [1:0] STEP_STRING = 2'h3;
  // register numbers
  localparam logic [2:0] REG_LOOP = 3'h4;
  localparam logic [2:0] REG_INDEX = 3'h5;
  localparam logic [2:0] REG_PAGE = 3'h6;
  localparam logic [2:0] REG_STACK = 3'h7;
  // operand typing from mnemonic suffix
  localparam logic [1:0] SUFFIX_WORD = 2'h0;
  localparam logic [1:0] SUFFIX_BYTE = 2'h1;
  localparam logic [1:0] SUFFIX_STRING = 2'h2;
  localparam logic [1:0] SUFFIX_BYTE_STRING = 2'h3;
  // clock and word counts, step sizes and reset values
  localparam int TWO_WORD_CLOCKS = 2;
  localparam int ONE_WORD_CLOCKS = 1;
  localparam int TWO_WORD_REPEAT_EXTRA = 4;
  localparam int ONE_WORD_REPEAT_EXTRA = 2;
  localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
  localparam logic [ADDR_W-1:0] BYTE_STEP = 16'h0001;
  localparam logic [ADDR_W-1:0] FLAG_BASE = 16'h0000;
  localparam logic [ADDR_W-1:0] REG_RESET = 16'h0000;
  localparam logic [AP_W-1:0] AP_RESET = 5'h00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WORD2 = 4'b0010,
    ST_STRING = 4'b0100,
    ST_DONE = 4'b1000
  } dec_state_t;
endpackage

//--- rtl/addr_reg_file.sv
// Purpose: eight 16-bit address registers with a decoder write port and an external load port
// Assumes: write and load requests never both target one cycle conflicting
// Notes: the decoder write has priority over the external load
`timescale 1ns/1ps
`default_nettype none
module addr_reg_file #(
  parameter int WIDTH = 16,
  parameter int COUNT = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [$clog2(COUNT)-1:0] wr_sel,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic load_en,
  input wire logic [$clog2(COUNT)-1:0] load_sel,
  input wire logic [WIDTH-1:0] load_data,
  output logic [WIDTH*COUNT-1:0] regs_flat
);
  import opaddr_pkg::*;
  logic [WIDTH-1:0] regs [COUNT];
  logic [WIDTH-1:0] next_regs [COUNT];
  initial begin
    if (COUNT < 8 || WIDTH != ADDR_W) $error("addr_reg_file: unsupported size");
  end
  always_comb begin
    for (int i = 0; i < COUNT; i++) begin
      next_regs[i] = regs[i];
      if (load_en && load_sel == i[$clog2(COUNT)-1:0]) next_regs[i] = load_data;
      if (wr_en && wr_sel == i[$clog2(COUNT)-1:0]) next_regs[i] = wr_data;
    end
  end
  always_ff @(posedge clk) begin
    for (int i = 0; i < COUNT; i++) begin
      if (!reset_n) regs[i] <= REG_RESET;
      else regs[i] <= next_regs[i];
    end
  end
  genvar g;
  generate
    for (g = 0; g < COUNT; g++) begin : flat
      assign regs_flat[g*WIDTH +: WIDTH] = regs[g];
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/acc_pointer_unit.sv
// Purpose: four 5-bit accumulator pointers with pre-step
// Assumes: one step request per instruction start
// Notes: wraps modulo 32, as the pointers are 5 bits
`timescale 1ns/1ps
`default_nettype none
module acc_pointer_unit #(
  parameter int AP_BITS = 5,
  parameter int POINTERS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step_en,
  input wire logic [$clog2(POINTERS)-1:0] step_sel,
  input wire logic [1:0] step_code,
  input wire logic load_en,
  input wire logic [$clog2(POINTERS)-1:0] load_sel,
  input wire logic [AP_BITS-1:0] load_data,
  output logic [AP_BITS*POINTERS-1:0] ap_flat
);
  import opaddr_pkg::*;
  logic [AP_BITS-1:0] ap [POINTERS];
  logic [AP_BITS-1:0] next_ap [POINTERS];
  initial begin
    if (AP_BITS != AP_W || POINTERS != NUM_AP) $error("acc_pointer_unit: unsupported size");
  end
  always_comb begin
    for (int i = 0; i < POINTERS; i++) begin
      next_ap[i] = ap[i];
      if (load_en && load_sel == i[$clog2(POINTERS)-1:0]) next_ap[i] = load_data;
      if (step_en && step_sel == i[$clog2(POINTERS)-1:0]) begin
        // RQ18 five-bit wrap
        case (step_code)
          STEP_PREDEC: next_ap[i] = ap[i] - 5'h01;
          STEP_PREINC: next_ap[i] = ap[i] + 5'h01;
          default: next_ap[i] = ap[i];
        endcase
      end
    end
  end
  always_ff @(posedge clk) begin
    for (int i = 0; i < POINTERS; i++) begin
      if (!reset_n) ap[i] <= AP_RESET;
      else ap[i] <= next_ap[i];
    end
  end
  genvar g;
  generate
    for (g = 0; g < POINTERS; g++) begin : flat
      assign ap_flat[g*AP_BITS +: AP_BITS] = ap[g];
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/operand_address_decoder.sv
// Purpose: decode operand addressing bits and produce data-memory addresses
// Assumes: pipeline presents opcode with start, and second word with word_valid
// Notes: one operand per instruction; string length given as word count
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: direct mode uses second word unmodified
// RQ2: index mode adds index register, base kept
// RQ3: long relative adds 16-bit second word
// RQ4: bit 7 set: page plus 7-bit offset
// RQ5: indirect uses register, then post-modifies
// RQ6: fields decoded from opcode bits 0..7
// RQ7: post-modify field zero outside indirect
// RQ8: base field selects one of eight registers
// RQ9: bits 10,11 step accumulator pointer
// RQ10: strings use temporary address copy
// RQ11: post-modified strings write back each cycle
// RQ12: global flag address from bits 1..6
// RQ13: relative flag offset added to page
// RQ14: clocks and words per mode
// RQ15: suffix selects byte or string operands
// RQ16: at most one destination per instruction
// RQ17: post-step two for words, one bytes
// RQ18: accumulator pointers are five bits
// RQ19: sums wrap in 16-bit arithmetic
module operand_address_decoder #(
  parameter int REPEAT_BITS = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [opaddr_pkg::OPCODE_W-1:0] opcode,
  input wire logic flag_instr,
  input wire logic step_allowed,
  input wire logic [1:0] ap_select,
  input wire logic [1:0] suffix,
  input wire logic [5:0] string_words,
  input wire logic [REPEAT_BITS-1:0] repeat_count,
  input wire logic repeat_active,
  input wire logic word_valid,
  input wire logic [opaddr_pkg::ADDR_W-1:0] second_word,
  input wire logic reg_load_en,
  input wire logic [2:0] reg_load_sel,
  input wire logic [opaddr_pkg::ADDR_W-1:0] reg_load_data,
  input wire logic ap_load_en,
  input wire logic [1:0] ap_load_sel,
  input wire logic [opaddr_pkg::AP_W-1:0] ap_load_data,
  output logic busy,
  output logic need_second_word,
  output logic addr_valid,
  output logic [opaddr_pkg::ADDR_W-1:0] eff_addr,
  output logic byte_operand,
  output logic string_operand,
  output logic flag_address,
  output logic encoding_error,
  output logic [1:0] word_count,
  output logic [REPEAT_BITS+2:0] clock_count,
  output logic [opaddr_pkg::ADDR_W*8-1:0] regs_flat,
  output logic [opaddr_pkg::AP_W*opaddr_pkg::NUM_AP-1:0] ap_flat
);
  import opaddr_pkg::*;

  initial begin
    if (REPEAT_BITS < 1 || REPEAT_BITS > 16) $error("operand_address_decoder: bad REPEAT_BITS");
  end

  dec_state_t state, next_state;
  logic [7:0] op_lo, next_op_lo;
  logic [ADDR_W-1:0] temp_addr, next_temp_addr;
  logic [5:0] remaining, next_remaining;
  logic is_byte, next_is_byte;
  logic is_string, next_is_string;
  logic next_addr_valid, next_flag_address, next_encoding_error, next_need_second;
  logic [ADDR_W-1:0] next_eff_addr;
  logic [1:0] next_word_count;
  logic [REPEAT_BITS+2:0] next_clock_count;
  logic wr_en;
  logic [2:0] wr_sel;
  logic [ADDR_W-1:0] wr_data;
  logic ap_step_en;

  logic [ADDR_W-1:0] regs [8];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : unpack
      assign regs[g] = regs_flat[g*ADDR_W +: ADDR_W];
    end
  endgenerate

  // RQ6 field decode from the low byte
  logic [7:0] cur_lo;
  logic [2:0] mode;
  logic [2:0] base_sel;
  logic [1:0] post;
  logic short_mode;
  assign cur_lo = (state == ST_IDLE) ? opcode[7:0] : op_lo;
  assign mode = cur_lo[MODE_MSB:MODE_LSB];
  assign base_sel = cur_lo[BASE_MSB:BASE_LSB];
  assign post = cur_lo[POST_MSB:POST_LSB];
  assign short_mode = cur_lo[SHORT_FLAG_BIT];

  // RQ8 register selection by binary value
  logic [ADDR_W-1:0] base_val;
  assign base_val = regs[base_sel];

  logic [ADDR_W-1:0] step;
  logic [ADDR_W-1:0] post_val;
  // RQ17 address registers step by operand size
  // at start the new suffix is not registered yet, so the first write-back must use it directly
  assign step = ((state == ST_IDLE) ? (suffix == SUFFIX_BYTE || suffix == SUFFIX_BYTE_STRING) : is_byte)
                ? BYTE_STEP : WORD_STEP;
  // RQ5 post modification, RQ19 wraps
  always_comb begin
    case (post)
      POST_INC: post_val = base_val + step;
      POST_DEC: post_val = base_val - step;
      POST_ADD_INDEX: post_val = base_val + regs[REG_INDEX];
      default: post_val = base_val;
    endcase
  end

  logic two_word;
  assign two_word = !flag_instr && !short_mode && (mode == MODE_DIRECT || mode == MODE_LONG);

  always_comb begin
    next_state = state;
    next_op_lo = op_lo;
    next_temp_addr = temp_addr;
    next_remaining = remaining;
    next_is_byte = is_byte;
    next_is_string = is_string;
    next_addr_valid = 1'b0;
    next_flag_address = flag_address;
    next_encoding_error = encoding_error;
    next_need_second = 1'b0;
    next_eff_addr = eff_addr;
    next_word_count = word_count;
    next_clock_count = clock_count;
    wr_en = 1'b0;
    wr_sel = base_sel;
    wr_data = post_val;
    ap_step_en = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_op_lo = opcode[7:0];
          // RQ15 suffix typing
          next_is_byte = (suffix == SUFFIX_BYTE) || (suffix == SUFFIX_BYTE_STRING);
          next_is_string = (suffix == SUFFIX_STRING) || (suffix == SUFFIX_BYTE_STRING)
                           || (step_allowed && opcode[STEP_MSB:STEP_LSB] == STEP_STRING);
          next_remaining = string_words;
          next_flag_address = flag_instr;
          // RQ9 pre-step accumulator pointer
          ap_step_en = step_allowed;
          // RQ7 nonzero post field flagged
          next_encoding_error = !flag_instr && !short_mode && mode != MODE_INDIRECT && post != POST_NONE;
          // RQ14 word and clock counts
          next_word_count = two_word ? 2'd2 : 2'd1;
          if (two_word) begin
            next_clock_count = repeat_active
              ? (REPEAT_BITS+3)'(repeat_count) + (REPEAT_BITS+3)'(TWO_WORD_REPEAT_EXTRA)
              : (REPEAT_BITS+3)'(TWO_WORD_CLOCKS);
          end else begin
            next_clock_count = repeat_active
              ? (REPEAT_BITS+3)'(repeat_count) + (REPEAT_BITS+3)'(ONE_WORD_REPEAT_EXTRA)
              : (REPEAT_BITS+3)'(ONE_WORD_CLOCKS);
          end
          if (flag_instr) begin
            // RQ12 global flag, RQ13 relative flag
            if (!opcode[FLAG_REL_BIT])
              next_eff_addr = FLAG_BASE + {10'h000, opcode[FLAG_OFS_MSB:FLAG_OFS_LSB]};
            else
              next_eff_addr = regs[REG_PAGE] + {10'h000, opcode[FLAG_OFS_MSB:FLAG_OFS_LSB]};
            next_addr_valid = 1'b1;
            next_state = ST_DONE;
          end else if (short_mode) begin
            // RQ4 page relative, page kept
            next_eff_addr = regs[REG_PAGE] + {9'h000, opcode[SHORT_OFS_MSB:0]};
            next_addr_valid = 1'b1;
          end else if (two_word) begin
            next_need_second = 1'b1;
            next_state = ST_WORD2;
          end else if (mode == MODE_INDEX) begin
            // RQ2 base plus index, base kept
            next_eff_addr = base_val + regs[REG_INDEX];
            next_addr_valid = 1'b1;
          end else begin
            // RQ5 indirect address is register
            next_eff_addr = base_val;
            next_addr_valid = 1'b1;
            // RQ11 write back modified address; RQ16 single destination
            wr_en = (mode == MODE_INDIRECT) && post != POST_NONE;
          end
          if (!flag_instr && !two_word) begin
            next_state = ST_DONE;
            if (next_is_string && string_words != 6'd0) begin
              next_state = ST_STRING;
              // RQ10 temporary copy for non post-modified
              next_temp_addr = next_eff_addr + step;
            end
          end
        end
      end
      ST_WORD2: begin
        next_need_second = !word_valid;
        if (word_valid) begin
          // RQ1 direct word, RQ3 long offset
          next_eff_addr = (mode == MODE_DIRECT) ? second_word : base_val + second_word;
          next_addr_valid = 1'b1;
          next_state = ST_DONE;
          if (is_string && remaining != 6'd0) begin
            next_state = ST_STRING;
            next_temp_addr = next_eff_addr + step;
          end
        end
      end
      ST_STRING: begin
        next_addr_valid = 1'b1;
        next_remaining = remaining - 6'd1;
        if (!short_mode && mode == MODE_INDIRECT && post != POST_NONE) begin
          // RQ11 every cycle writes back
          next_eff_addr = base_val;
          wr_en = 1'b1;
        end else begin
          // RQ10 registers untouched
          next_eff_addr = temp_addr;
          next_temp_addr = temp_addr + step;
        end
        if (remaining == 6'd1) next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      op_lo <= 8'h00;
      temp_addr <= REG_RESET;
      remaining <= 6'd0;
      is_byte <= 1'b0;
      is_string <= 1'b0;
      addr_valid <= 1'b0;
      flag_address <= 1'b0;
      encoding_error <= 1'b0;
      need_second_word <= 1'b0;
      eff_addr <= REG_RESET;
      word_count <= 2'd0;
      clock_count <= '0;
    end else begin
      state <= next_state;
      op_lo <= next_op_lo;
      temp_addr <= next_temp_addr;
      remaining <= next_remaining;
      is_byte <= next_is_byte;
      is_string <= next_is_string;
      addr_valid <= next_addr_valid;
      flag_address <= next_flag_address;
      encoding_error <= next_encoding_error;
      need_second_word <= next_need_second;
      eff_addr <= next_eff_addr;
      word_count <= next_word_count;
      clock_count <= next_clock_count;
    end
  end

  assign busy = (state != ST_IDLE);
  assign byte_operand = is_byte;
  assign string_operand = is_string;

  addr_reg_file #(.WIDTH(ADDR_W), .COUNT(8)) u_regs (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .load_en(reg_load_en),
    .load_sel(reg_load_sel),
    .load_data(reg_load_data),
    .regs_flat(regs_flat)
  );

  acc_pointer_unit #(.AP_BITS(AP_W), .POINTERS(NUM_AP)) u_ap (
    .clk(clk),
    .reset_n(reset_n),
    .step_en(ap_step_en),
    .step_sel(ap_select),
    .step_code(opcode[STEP_MSB:STEP_LSB]),
    .load_en(ap_load_en),
    .load_sel(ap_load_sel),
    .load_data(ap_load_data),
    .ap_flat(ap_flat)
  );
endmodule
`default_nettype wire

//--- verif/opaddr_asserts.sv
// Purpose: port-level checks of the operand address decoder
// Assumes: address registers are not loaded while an instruction runs
// Notes: sums wrap at 16 bits, as the hardware does
`timescale 1ns/1ps
`default_nettype none
module opaddr_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [opaddr_pkg::OPCODE_W-1:0] opcode,
  input wire logic flag_instr,
  input wire logic [1:0] suffix,
  input wire logic busy,
  input wire logic word_valid,
  input wire logic [opaddr_pkg::ADDR_W-1:0] second_word,
  input wire logic need_second_word,
  input wire logic addr_valid,
  input wire logic [opaddr_pkg::ADDR_W-1:0] eff_addr,
  input wire logic flag_address,
  input wire logic [opaddr_pkg::ADDR_W*8-1:0] regs_flat
);
  import opaddr_pkg::*;
  logic tk;
  logic go;
  logic [5:0] held;
  logic [5:0] next_held;
  function automatic logic [15:0] rg(input logic [127:0] f, input logic [2:0] s);
    return f[s*16+:16];
  endfunction
  assign tk = start && !busy;
  assign go = tk && !flag_instr && !opcode[7];
  // mode and base register kept while the second word is awaited
  always_comb begin
    next_held = tk ? opcode[7:2] : held;
  end
  always_ff @(posedge clk) begin
    held <= next_held;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_short; tk && !flag_instr && opcode[7] |=>
    addr_valid && eff_addr == rg($past(regs_flat), REG_PAGE) + 16'($past(opcode[6:0])); endproperty
  a_short: assert property (p_short) else $error("short relative address wrong");
  property p_index; go && opcode[6:5] == 2'h2 |=> addr_valid && regs_flat == $past(regs_flat) &&
    eff_addr == rg($past(regs_flat), $past(opcode[4:2])) + rg($past(regs_flat), REG_INDEX); endproperty
  a_index: assert property (p_index) else $error("index relative address wrong");
  property p_wait; go && !opcode[6] |=> need_second_word && !addr_valid; endproperty
  a_wait: assert property (p_wait) else $error("two-word mode did not wait");
  property p_direct; need_second_word && word_valid && held[5:3] == MODE_DIRECT |=>
    addr_valid && eff_addr == $past(second_word); endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_long; need_second_word && word_valid && held[5:3] == MODE_LONG |=>
    addr_valid && eff_addr == $past(second_word) + rg($past(regs_flat), held[2:0]); endproperty
  a_long: assert property (p_long) else $error("long relative address wrong");
  property p_glob; tk && flag_instr && !opcode[0] |=>
    addr_valid && flag_address && eff_addr == 16'($past(opcode[6:1])); endproperty
  a_glob: assert property (p_glob) else $error("global flag address wrong");
  property p_rel; tk && flag_instr && opcode[0] |=> addr_valid && flag_address &&
    eff_addr == rg($past(regs_flat), REG_PAGE) + 16'($past(opcode[6:1])); endproperty
  a_rel: assert property (p_rel) else $error("relative flag address wrong");
  property p_inc; go && opcode[6:5] == 2'h3 && opcode[1:0] == POST_INC && suffix == SUFFIX_WORD |=>
    addr_valid && eff_addr == rg($past(regs_flat), $past(opcode[4:2])) &&
    rg(regs_flat, $past(opcode[4:2])) == eff_addr + WORD_STEP; endproperty
  a_inc: assert property (p_inc) else $error("word post increment wrong");
endmodule
bind operand_address_decoder opaddr_asserts u_opaddr_asserts (
  .clk(clk), .reset_n(reset_n), .start(start), .opcode(opcode), .flag_instr(flag_instr),
  .suffix(suffix), .busy(busy), .word_valid(word_valid), .second_word(second_word),
  .need_second_word(need_second_word), .addr_valid(addr_valid), .eff_addr(eff_addr),
  .flag_address(flag_address), .regs_flat(regs_flat)
);
`default_nettype wire

//--- verif/fetch_model.sv
// Purpose: fetch pipeline model handing over second instruction words
// Assumes: the word is offered for one cycle only
// Notes: outside the hand-over the line toggles so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  input wire logic clk,
  input wire logic need_second_word,
  input wire logic [15:0] word_in,
  input wire logic [1:0] delay,
  output logic word_valid,
  output logic [15:0] second_word
);
  logic [1:0] cnt;
  initial begin
    word_valid = 1'b0;
    second_word = 16'h0000;
    cnt = 2'h0;
  end
  always @(posedge clk) begin
    if (word_valid) begin
      word_valid <= 1'b0;
      second_word <= ~word_in;
    end else if (need_second_word && cnt == delay) begin
      word_valid <= 1'b1;
      second_word <= word_in;
    end else begin
      cnt <= need_second_word ? cnt + 2'h1 : 2'h0;
      second_word <= ~second_word;
    end
  end
endmodule
`default_nettype wire

//--- verif/operand_address_decoder_tb.sv
// Purpose: self-checking bench for the operand address decoder
// Assumes: loads happen only while the decoder is idle
// Notes: seeded random opcodes plus string, boundary and flag cases
`timescale 1ns/1ps
`default_nettype none
module operand_address_decoder_tb;
  import opaddr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic flag_instr = 1'b0;
  logic step_allowed = 1'b0;
  logic repeat_active = 1'b0;
  logic reg_load_en = 1'b0;
  logic ap_load_en = 1'b0;
  logic [16:0] opcode = 17'h00000;
  logic [1:0] ap_select = 2'h0;
  logic [1:0] suffix = 2'h0;
  logic [1:0] ap_load_sel = 2'h0;
  logic [1:0] delay = 2'h0;
  logic [5:0] string_words = 6'h00;
  logic [7:0] repeat_count = 8'h00;
  logic [2:0] reg_load_sel = 3'h0;
  logic [15:0] reg_load_data = 16'h0000;
  logic [4:0] ap_load_data = 5'h00;
  logic [15:0] word_in = 16'h0000;
  logic word_valid, busy, need_second_word, addr_valid, byte_operand, string_operand, flag_address, enc_err;
  logic [15:0] second_word, eff_addr;
  logic [1:0] word_count;
  logic [10:0] clock_count;
  logic [127:0] regs_flat;
  logic [19:0] ap_flat;
  logic [15:0] r [8];
  logic [4:0] ap [4];
  logic [15:0] q [$];
  integer seed = 32'h36d1;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  operand_address_decoder u_operand_address_decoder (.clk(clk), .reset_n(reset_n), .start(start),
    .opcode(opcode), .flag_instr(flag_instr), .step_allowed(step_allowed), .ap_select(ap_select),
    .suffix(suffix), .string_words(string_words), .repeat_count(repeat_count), .repeat_active(repeat_active),
    .word_valid(word_valid), .second_word(second_word), .reg_load_en(reg_load_en), .reg_load_sel(reg_load_sel),
    .reg_load_data(reg_load_data), .ap_load_en(ap_load_en), .ap_load_sel(ap_load_sel),
    .ap_load_data(ap_load_data), .busy(busy), .need_second_word(need_second_word), .addr_valid(addr_valid),
    .eff_addr(eff_addr), .byte_operand(byte_operand), .string_operand(string_operand),
    .flag_address(flag_address), .encoding_error(enc_err), .word_count(word_count), .clock_count(clock_count),
    .regs_flat(regs_flat), .ap_flat(ap_flat));
  fetch_model u_fetch_model (.clk(clk), .need_second_word(need_second_word), .word_in(word_in),
    .delay(delay), .word_valid(word_valid), .second_word(second_word));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    return $random(seed) | 32'h20000000;
  endfunction
  // address of the first operand word; indirect mode is modelled in run
  function automatic logic [15:0] base_addr(input logic [16:0] op, input logic fl, input logic [15:0] w);
    if (fl) return (op[0] ? r[6] : FLAG_BASE) + 16'(op[6:1]);
    if (op[7]) return r[6] + 16'(op[6:0]);
    if (op[6:5] == 2'h2) return r[op[4:2]] + r[5];
    return (op[5] ? r[op[4:2]] : 16'h0000) + w;
  endfunction
  task automatic cmp_state();
    for (int i = 0; i < 8; i++) chk(128'(regs_flat[i*16+:16]), 128'(r[i]));
    chk(128'(ap_flat), 128'({ap[3], ap[2], ap[1], ap[0]}));
  endtask
  task automatic run(input logic [16:0] op, input logic fl, input logic [1:0] sf, input logic [5:0] sw,
                     input logic [31:0] rv);
    logic [15:0] w;
    logic [15:0] a;
    logic [15:0] st;
    logic [2:0] s;
    logic two;
    int n;
    w = 16'($random(seed));
    s = op[4:2];
    st = sf[0] ? BYTE_STEP : WORD_STEP;
    two = !fl && op[7:6] == 2'h0;
    a = base_addr(op, fl, w);
    q.delete();
    for (int i = 0; i <= sw; i++) begin
      if (!fl && op[7:5] == MODE_INDIRECT) begin
        q.push_back(r[s]);
        if (op[1:0] == POST_INC) r[s] = r[s] + st;
        if (op[1:0] == POST_DEC) r[s] = r[s] - st;
        if (op[1:0] == POST_ADD_INDEX) r[s] = r[s] + r[5];
      end else begin
        q.push_back(a + 16'(i) * st);
      end
    end
    if (rv[29] && op[11:10] == STEP_PREDEC) ap[rv[31:30]] = ap[rv[31:30]] - 5'h01;
    if (rv[29] && op[11:10] == STEP_PREINC) ap[rv[31:30]] = ap[rv[31:30]] + 5'h01;
    @(posedge clk);
    start <= 1'b1;
    opcode <= op;
    flag_instr <= fl;
    suffix <= sf;
    string_words <= sw;
    step_allowed <= rv[29];
    ap_select <= rv[31:30];
    repeat_active <= rv[20];
    repeat_count <= rv[28:21];
    word_in <= w;
    delay <= rv[13:12];
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    for (int k = 0; k < 12 && n <= sw; k++) begin
      #2;
      if (n > 0) chk(128'(addr_valid), 128'h1);
      if (addr_valid === 1'b1) begin
        chk(128'(eff_addr), 128'(q[n]));
        n++;
      end
      @(posedge clk);
    end
    @(posedge clk);
    #2;
    chk(128'(n), 128'(sw) + 128'h1);
    chk(128'(busy), 128'h0);
    chk(128'(word_count), two ? 128'h2 : 128'h1);
    chk(128'(clock_count), rv[20] ? 128'(rv[28:21]) + (two ? 128'h4 : 128'h2) : (two ? 128'h2 : 128'h1));
    chk(128'({byte_operand, string_operand, flag_address}), 128'({sf[0], sf[1] | (rv[29] && op[11:10] == STEP_STRING), fl}));
    chk(128'(enc_err), 128'(!fl && !op[7] && op[6:5] != 2'h3 && op[1:0] != 2'h0));
    cmp_state();
  endtask
  initial begin
    logic [31:0] rv;
    logic [16:0] op;
    int k;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #2;
    chk(regs_flat | 128'(ap_flat), 128'h0);
    for (int i = 0; i < 8; i++) begin
      rv = $random(seed);
      r[i] = rv[15:0];
      ap[i % 4] = rv[20:16];
      @(posedge clk);
      reg_load_en <= 1'b1;
      reg_load_sel <= 3'(i);
      reg_load_data <= rv[15:0];
      ap_load_en <= 1'b1;
      ap_load_sel <= 2'(i % 4);
      ap_load_data <= rv[20:16];
    end
    @(posedge clk);
    reg_load_en <= 1'b0;
    ap_load_en <= 1'b0;
    @(posedge clk);
    #2;
    cmp_state();
    run(17'h00465, 1'b0, SUFFIX_STRING, 6'h03, rnd());
    run(17'h0084C, 1'b0, SUFFIX_BYTE_STRING, 6'h02, rnd());
    run(17'h000FF, 1'b0, SUFFIX_BYTE, 6'h00, rnd());
    run(17'h0007B, 1'b0, SUFFIX_WORD, 6'h00, rnd());
    run(17'h00076, 1'b0, SUFFIX_BYTE, 6'h00, rnd());
    run(17'h0007F, 1'b1, SUFFIX_WORD, 6'h00, rnd());
    run(17'h0007E, 1'b1, SUFFIX_WORD, 6'h00, rnd());
    run(17'h0003C, 1'b0, SUFFIX_WORD, 6'h00, rnd());
    run(17'h00000, 1'b0, SUFFIX_WORD, 6'h00, rnd());
    run(17'h0004D, 1'b0, SUFFIX_WORD, 6'h00, rnd());
    for (int i = 0; i < 80; i++) begin
      rv = $random(seed);
      k = $unsigned($random(seed)) % 7;
      op = rv[16:0];
      if (k < 3) op[7:0] = {3'(k), k == 0 ? 3'h0 : op[4:2], 2'h0};
      else if (k == 3) op[7:5] = MODE_INDIRECT;
      else if (k == 4) op[7] = 1'b1;
      else op[7:0] = {1'b0, op[6:1], k == 5};
      run(op, k > 4, rv[19:18], 6'h00, rv);
    end
    results();
  end
endmodule
`default_nettype wire
